/* File: irq_front_pkg.sv */
// constants, register map and carrier types of the interrupt request front end
`default_nettype none
package irq_front_pkg;
    // widths
    localparam int ADR_W    = 5;              // byte address width of the register window
    localparam int DAT_W    = 32;             // bus data width
    localparam int SEL_W    = 4;              // byte lanes
    localparam int NUM_REQ  = 4;              // maskable request pins
    localparam int EV_W     = 5;              // event bits: four maskable plus non-maskable
    localparam int TYPE_W   = 8;              // interrupt type width

    // register byte offsets
    localparam logic [ADR_W-1:0] OFS_CTRL = 5'h00;  // trigger modes, pin roles, slave mode
    localparam logic [ADR_W-1:0] OFS_PEND = 5'h04;  // live pending view, read only
    localparam logic [ADR_W-1:0] OFS_STAT = 5'h08;  // sticky events, write one to clear
    localparam logic [ADR_W-1:0] OFS_MASK = 5'h0C;  // interrupt line enables

    // control fields
    localparam int CTRL_LEVEL_LSB = 0;        // four bits, one per pin: 1 = level trigger
    localparam int CTRL_ACK_A_BIT = 4;        // pin c drives ack strobe a
    localparam int CTRL_ACK_B_BIT = 5;        // pin d drives ack strobe b
    localparam int CTRL_SLAVE_BIT = 6;        // slave mode: pins leave normal input role
    localparam int CTRL_W         = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

    // status and mask fields
    localparam int STAT_NMI_BIT = 4;          // non-maskable event bit
    localparam logic [EV_W-1:0] STAT_RST  = 5'h00;
    localparam logic [EV_W-1:0] MASK_RST  = 5'h10;  // non-maskable bit always enabled
    localparam logic [EV_W-1:0] MASK_FIX  = 5'h10;  // bits that cannot be cleared

    // pin indices and acknowledge indices
    localparam int PIN_C = 2;                 // third maskable pin, shared with ack a
    localparam int PIN_D = 3;                 // fourth maskable pin, shared with ack b
    localparam logic [1:0] ACK_IDX_A = 2'h0;  // acknowledging request a strobes ack a
    localparam logic [1:0] ACK_IDX_B = 2'h1;  // acknowledging request b strobes ack b

    // interrupt type raised by the non-maskable input
    localparam logic [TYPE_W-1:0] NMI_TYPE = 8'h02;

    // classic wishbone request bundle
    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [ADR_W-1:0] adr;
        logic [SEL_W-1:0] sel;
        logic [DAT_W-1:0] dat;
    } wb_req_s;

    // non-maskable request sequencer
    typedef enum logic [1:0] {
        NMI_IDLE = 2'b00,
        NMI_PEND = 2'b01,
        NMI_TAKE = 2'b10
    } nmi_state_e;
endpackage
`default_nettype wire

/* File: irq_front_end.sv */
// interrupt request pin front end with wishbone register slave
`timescale 1ns/1ps
`default_nettype none

module irq_front_end
    import irq_front_pkg::*;
(
    // clock and reset
    input  wire  logic                clk_sys,
    input  wire  logic                rst,
    // wishbone slave
    input  wire  wb_req_s             wb_req,
    output logic                      wb_ack_q,
    output logic [DAT_W-1:0]          wb_dat_q,
    // request pins
    input  wire  logic                nmi_request,
    input  wire  logic                maskable_request_a,
    input  wire  logic                maskable_request_b,
    input  wire  logic                maskable_request_c_or_ack_a_in,
    output logic                      maskable_request_c_or_ack_a_out_n_q,
    output logic                      maskable_request_c_or_ack_a_oe_q,
    input  wire  logic                maskable_request_d_or_ack_b_in,
    output logic                      maskable_request_d_or_ack_b_out_n_q,
    output logic                      maskable_request_d_or_ack_b_oe_q,
    // processor core side
    input  wire  logic                instr_boundary,
    input  wire  logic                core_ack_valid,
    input  wire  logic [1:0]          core_ack_index,
    output logic                      nmi_take_q,
    output logic [TYPE_W-1:0]         nmi_type_q,
    output logic [NUM_REQ-1:0]        req_pending_q,
    // interrupt line
    output logic                      irq_q
);

    // registers
    logic [CTRL_W-1:0]  ctrl_q;       // control register
    logic [EV_W-1:0]    stat_q;       // sticky event bits
    logic [EV_W-1:0]    mask_q;       // interrupt line enables
    // synchronisers and edge history
    logic [NUM_REQ-1:0] req_meta_q;   // first stage, read only by second
    logic [NUM_REQ-1:0] req_sync_q;   // second stage
    logic [NUM_REQ-1:0] req_prev_q;   // history for edge detect
    logic [NUM_REQ-1:0] req_edge_q;   // latched edge requests
    logic               nmi_meta_q;   // first stage, read only by second
    logic               nmi_sync_q;   // second stage
    logic               nmi_prev_q;   // history for edge detect
    nmi_state_e         nmi_state_q;  // non-maskable sequencer
    // combinational helpers
    logic [NUM_REQ-1:0] pins;         // raw pin vector
    logic [NUM_REQ-1:0] pin_is_out;   // pins currently acting as ack outputs
    logic [NUM_REQ-1:0] req_live;     // synchronised requests allowed in
    logic [NUM_REQ-1:0] req_rise;     // rising edges of allowed requests
    logic [NUM_REQ-1:0] ack_hit;      // core acknowledge decoded per request
    logic [NUM_REQ-1:0] level_mode;   // per pin trigger choice
    logic               slave_mode;   // slave mode selected
    logic               nmi_rise;     // synchronised non-maskable rising edge
    logic [EV_W-1:0]    events;       // event vector for the status register
    logic               bus_req;      // new wishbone access this cycle
    logic               wr_lo;        // write to low byte lane

    // field extraction
    assign level_mode = ctrl_q[CTRL_LEVEL_LSB +: NUM_REQ];
    assign slave_mode = ctrl_q[CTRL_SLAVE_BIT];
    assign pins       = {maskable_request_d_or_ack_b_in, maskable_request_c_or_ack_a_in,
                         maskable_request_b, maskable_request_a};

    // pins c and d stop being inputs while they carry acks
    always_comb begin
        pin_is_out        = '0;
        pin_is_out[PIN_C] = ctrl_q[CTRL_ACK_A_BIT];
        pin_is_out[PIN_D] = ctrl_q[CTRL_ACK_B_BIT];
    end

    // per pin synchroniser, edge detect and edge latch
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REQ; gi++) begin : g_req
            // two stage synchroniser plus history
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    req_meta_q[gi] <= 1'b0;
                    req_sync_q[gi] <= 1'b0;
                    req_prev_q[gi] <= 1'b0;
                end else begin
                    req_meta_q[gi] <= pins[gi];
                    req_sync_q[gi] <= req_meta_q[gi];
                    req_prev_q[gi] <= req_sync_q[gi];
                end
            end

            // output-role pins and slave mode gate the input off
            assign req_live[gi] = req_sync_q[gi] & ~pin_is_out[gi] & ~slave_mode;
            assign req_rise[gi] = req_live[gi] & ~req_prev_q[gi];
            assign ack_hit[gi]  = core_ack_valid && (core_ack_index == 2'(gi));

            // edge latch: a new edge wins over an acknowledge in the same cycle
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    req_edge_q[gi] <= 1'b0;
                end else if (req_rise[gi]) begin
                    req_edge_q[gi] <= 1'b1;
                end else if (ack_hit[gi] || slave_mode || level_mode[gi]) begin
                    req_edge_q[gi] <= 1'b0;
                end
            end

            // pending view: level follows the pin, edge uses the latch
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    req_pending_q[gi] <= 1'b0;
                end else if (level_mode[gi]) begin
                    req_pending_q[gi] <= req_live[gi];
                end else begin
                    req_pending_q[gi] <= req_edge_q[gi] | req_rise[gi];
                end
            end
        end
    endgenerate

    // non-maskable synchroniser and history
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            nmi_meta_q <= 1'b0;
            nmi_sync_q <= 1'b0;
            nmi_prev_q <= 1'b0;
        end else begin
            nmi_meta_q <= nmi_request;
            nmi_sync_q <= nmi_meta_q;
            nmi_prev_q <= nmi_sync_q;
        end
    end

    // a pin high for one clock still leaves one synchronised rise
    assign nmi_rise = nmi_sync_q & ~nmi_prev_q;

    // sequencer: latch, wait for boundary, take; a new edge wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            nmi_state_q <= NMI_IDLE;
        end else begin
            unique case (nmi_state_q)
                NMI_IDLE: begin
                    if (nmi_rise) begin
                        nmi_state_q <= NMI_PEND;
                    end
                end
                NMI_PEND: begin
                    if (instr_boundary && !nmi_rise) begin
                        nmi_state_q <= NMI_TAKE;
                    end
                end
                NMI_TAKE: begin
                    // an edge arriving while taken starts a fresh request
                    nmi_state_q <= nmi_rise ? NMI_PEND : NMI_IDLE;
                end
                default: begin
                    nmi_state_q <= NMI_IDLE;
                end
            endcase
        end
    end

    // take pulse and type: no register takes part, nothing can mask it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            nmi_take_q <= 1'b0;
            nmi_type_q <= NMI_TYPE;
        end else begin
            nmi_take_q <= (nmi_state_q == NMI_PEND) && instr_boundary && !nmi_rise;
            nmi_type_q <= NMI_TYPE;
        end
    end

    // active-low ack strobes and their enables
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            maskable_request_c_or_ack_a_out_n_q <= 1'b1;
            maskable_request_d_or_ack_b_out_n_q <= 1'b1;
            maskable_request_c_or_ack_a_oe_q    <= 1'b0;
            maskable_request_d_or_ack_b_oe_q    <= 1'b0;
        end else begin
            maskable_request_c_or_ack_a_oe_q    <= ctrl_q[CTRL_ACK_A_BIT];
            maskable_request_d_or_ack_b_oe_q    <= ctrl_q[CTRL_ACK_B_BIT];
            maskable_request_c_or_ack_a_out_n_q <= !(ctrl_q[CTRL_ACK_A_BIT] && core_ack_valid
                                                     && core_ack_index == ACK_IDX_A);
            maskable_request_d_or_ack_b_out_n_q <= !(ctrl_q[CTRL_ACK_B_BIT] && core_ack_valid
                                                     && core_ack_index == ACK_IDX_B);
        end
    end

    // bus decode: a request counts only while no ack is out,
    // so a strobe still high in the ack cycle is never taken twice
    assign bus_req = wb_req.cyc && wb_req.stb && !wb_ack_q;
    assign wr_lo   = bus_req && wb_req.we && wb_req.sel[0];

    // control register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_lo && wb_req.adr == OFS_CTRL) begin
            ctrl_q <= wb_req.dat[CTRL_W-1:0];
        end
    end

    // mask register, non-maskable bit stays set
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mask_q <= MASK_RST;
        end else if (wr_lo && wb_req.adr == OFS_MASK) begin
            mask_q <= wb_req.dat[EV_W-1:0] | MASK_FIX;
        end
    end

    // sticky events, write one clears, a new event wins
    // an event in the clearing write's own cycle stays recorded
    assign events = {nmi_rise, req_rise};
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stat_q <= STAT_RST;
        end else if (wr_lo && wb_req.adr == OFS_STAT) begin
            stat_q <= (stat_q & ~wb_req.dat[EV_W-1:0]) | events;
        end else begin
            stat_q <= stat_q | events;
        end
    end

    // interrupt line, one cycle behind the status and mask bits
    // the non-maskable mask bit is forced on, so it always reaches here
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & mask_q);
        end
    end

    // bus answer: one cycle after the request, zero for unmapped
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= '0;
        end else begin
            wb_ack_q <= bus_req;
            if (bus_req && !wb_req.we) begin
                unique case (wb_req.adr)
                    OFS_CTRL: wb_dat_q <= DAT_W'(ctrl_q);
                    OFS_PEND: wb_dat_q <= DAT_W'({nmi_state_q != NMI_IDLE, req_pending_q});
                    OFS_STAT: wb_dat_q <= DAT_W'(stat_q);
                    OFS_MASK: wb_dat_q <= DAT_W'(mask_q);
                    default:  wb_dat_q <= '0;
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    nmi_type_fixed_a: assert property (nmi_take_q |-> nmi_type_q == NMI_TYPE)
        else $error("non-maskable take without type two");

    nmi_edge_latch_a: assert property (nmi_rise |=> nmi_state_q == NMI_PEND)
        else $error("non-maskable edge not latched");

    nmi_pin_path_a: assert property
        ($rose(nmi_request) ##1 1'b1 |=> nmi_rise || nmi_state_q != NMI_IDLE)
        else $error("non-maskable pin rise lost in synchroniser");

    nmi_boundary_a: assert property
        (nmi_take_q |-> $past(instr_boundary) && $past(nmi_state_q) == NMI_PEND)
        else $error("non-maskable taken outside boundary");

    nmi_no_block_a: assert property
        (nmi_state_q == NMI_PEND && instr_boundary && !nmi_rise |=> nmi_take_q)
        else $error("pending non-maskable not taken at boundary");

    nmi_irq_unmasked_a: assert property
        (stat_q[STAT_NMI_BIT] |=> irq_q)
        else $error("non-maskable status masked off line");

    // maskable path: level follow, edge hold and acknowledge, synchroniser
    level_follow_a: assert property
        (level_mode[0] && $stable(level_mode[0]) |=> req_pending_q[0] == $past(req_live[0]))
        else $error("level pending does not follow pin");

    edge_hold_a: assert property
        (!level_mode[0] && req_rise[0] ##1 (!ack_hit[0] && !slave_mode && !level_mode[0])
         |=> req_pending_q[0])
        else $error("edge request not held pending");

    edge_ack_clear_a: assert property
        (ack_hit[0] && !req_rise[0] |=> !req_edge_q[0])
        else $error("edge latch not cleared by acknowledge");

    stat_set_wins_a: assert property
        ((|events) |=> (stat_q & $past(events)) == $past(events))
        else $error("event lost against status clear");

    sync_delay_a: assert property
        (!slave_mode [*3] ##0 $rose(req_sync_q[0]) |-> $past(pins[0], 2))
        else $error("request bypassed synchroniser");

    // acknowledge strobes, slave mode and bus
    ack_strobe_a: assert property
        (ctrl_q[CTRL_ACK_A_BIT] && core_ack_valid && core_ack_index == ACK_IDX_A
         |=> !maskable_request_c_or_ack_a_out_n_q ##1 maskable_request_c_or_ack_a_oe_q)
        else $error("ack strobe a missing");

    ack_b_strobe_a: assert property
        (ctrl_q[CTRL_ACK_B_BIT] && core_ack_valid && core_ack_index == ACK_IDX_B
         |=> !maskable_request_d_or_ack_b_out_n_q)
        else $error("ack strobe b missing");

    slave_quiet_a: assert property
        (slave_mode [*2] |-> req_live == '0 ##1 req_edge_q == '0)
        else $error("slave mode still takes pin requests");

    bus_ack_once_a: assert property
        (bus_req |=> wb_ack_q ##1 !wb_ack_q)
        else $error("bus ack not a single cycle");

    // main scenarios reached
    nmi_taken_c:  cover property (nmi_rise ##[1:20] nmi_take_q);
    edge_ack_c:   cover property (req_rise[0] ##[1:20] ack_hit[0]);
    ack_out_c:    cover property (!maskable_request_d_or_ack_b_out_n_q);
    irq_c:        cover property ($rose(irq_q));
    level_pend_c: cover property (level_mode[1] && req_pending_q[1]);

endmodule
`default_nettype wire

/* File: irq_front_end_note_end.sv */
// intentionally empty companion file kept out of use
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: irq_source_model.sv */
// behavioural model of the external interrupt sources on the request pins
`timescale 1ns/1ps
`default_nettype none
module irq_source_model
    import irq_front_pkg::*;
(
    // clock and reset
    input  wire  logic            clk_sys,
    input  wire  logic            rst,
    // commands from the bench: bit4 non-maskable, bits3:0 pins a..d
    input  wire  logic [EV_W-1:0] raise,
    input  wire  logic [EV_W-1:0] drop,
    // device side of the shared pins
    input  wire  logic            oe_c,
    input  wire  logic            out_n_c,
    input  wire  logic            oe_d,
    input  wire  logic            out_n_d,
    // pin levels seen by the device
    output logic                  nmi_request,
    output logic                  req_a,
    output logic                  req_b,
    output logic                  pin_c,
    output logic                  pin_d
);
    logic [EV_W-1:0] level_q;  // request levels held by the sources

    // a request stays high until the bench says drop, which it may do with
    // or without an acknowledge from the device; nmi lasts at least one clock
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            level_q <= '0;
        end else begin
            level_q <= (level_q | raise) & ~drop;
        end
    end

    // shared pins: device strobe wins while its enable is high
    assign nmi_request = level_q[STAT_NMI_BIT];
    assign req_a       = level_q[0];
    assign req_b       = level_q[1];
    assign pin_c       = oe_c ? out_n_c : level_q[PIN_C];
    assign pin_d       = oe_d ? out_n_d : level_q[PIN_D];
endmodule
`default_nettype wire

/* File: interrupt_request_pin_front_end_bench.sv */
// self-checking bench for the interrupt request front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, act) begin check_count++; if ((act) !== (exp)) begin failures++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, act); end end
module interrupt_request_pin_front_end_bench
    import irq_front_pkg::*;
;
    logic                 clk_sys;         // 10 MHz system clock
    logic                 rst;             // synchronous reset
    wb_req_s              wb_req;          // bus request bundle
    logic                 wb_ack_q;        // bus answer
    logic [DAT_W-1:0]     wb_dat_q;        // read data
    logic                 nmi_request;     // pin levels from the model
    logic                 req_a;
    logic                 req_b;
    logic                 pin_c;
    logic                 pin_d;
    logic                 c_out_n;         // ack strobes and enables
    logic                 c_oe;
    logic                 d_out_n;
    logic                 d_oe;
    logic                 instr_boundary;  // core side inputs
    logic                 core_ack_valid;
    logic [1:0]           core_ack_index;
    logic                 nmi_take_q;      // core side outputs
    logic [TYPE_W-1:0]    nmi_type_q;
    logic [NUM_REQ-1:0]   req_pending_q;
    logic                 irq_q;
    logic [EV_W-1:0]      raise;           // model commands
    logic [EV_W-1:0]      drop;
    logic [DAT_W-1:0]     rd;              // last read word
    int                   failures;
    int                   check_count;
    int                   cycles;

    irq_front_end u_dut (
        .clk_sys(clk_sys), .rst(rst), .wb_req(wb_req), .wb_ack_q(wb_ack_q),
        .wb_dat_q(wb_dat_q), .nmi_request(nmi_request),
        .maskable_request_a(req_a), .maskable_request_b(req_b),
        .maskable_request_c_or_ack_a_in(pin_c),
        .maskable_request_c_or_ack_a_out_n_q(c_out_n),
        .maskable_request_c_or_ack_a_oe_q(c_oe),
        .maskable_request_d_or_ack_b_in(pin_d),
        .maskable_request_d_or_ack_b_out_n_q(d_out_n),
        .maskable_request_d_or_ack_b_oe_q(d_oe),
        .instr_boundary(instr_boundary), .core_ack_valid(core_ack_valid),
        .core_ack_index(core_ack_index), .nmi_take_q(nmi_take_q),
        .nmi_type_q(nmi_type_q), .req_pending_q(req_pending_q), .irq_q(irq_q));

    irq_source_model u_model (
        .clk_sys(clk_sys), .rst(rst), .raise(raise), .drop(drop),
        .oe_c(c_oe), .out_n_c(c_out_n), .oe_d(d_oe), .out_n_d(d_out_n),
        .nmi_request(nmi_request), .req_a(req_a), .req_b(req_b),
        .pin_c(pin_c), .pin_d(pin_d));

    // clock generator
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // hang guard: whole run is well under this many cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end

    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] dat);
        @(posedge clk_sys);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
        // ack ends this wait; only the hang guard ends it if ack never comes
        do begin
            @(posedge clk_sys);
        end while (wb_ack_q !== 1'b1);
        rd = wb_dat_q;
        wb_req <= '0;
    endtask

    // read a register and compare
    task automatic rdchk(input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] exp, input string nm);
        wb(1'b0, adr, '0);
        `CHK(nm, exp, rd)
    endtask

    // one-cycle command to the source model
    task automatic pins(input logic [EV_W-1:0] r, input logic [EV_W-1:0] d);
        @(posedge clk_sys);
        raise <= r;
        drop  <= d;
        @(posedge clk_sys);
        raise <= '0;
        drop  <= '0;
    endtask

    // wait edges, then step past them so outputs are settled
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // one-cycle core acknowledge
    task automatic core_ack(input logic [1:0] idx);
        @(posedge clk_sys);
        core_ack_valid <= 1'b1;
        core_ack_index <= idx;
        @(posedge clk_sys);
        core_ack_valid <= 1'b0;
        #1;
    endtask

    task automatic end_test(input string nm);
        $display("test %s ended: %0d checks, %0d mismatches", nm, check_count, failures);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        wb_req = '0;
        raise = '0;
        drop = '0;
        instr_boundary = 1'b0;
        core_ack_valid = 1'b0;
        core_ack_index = 2'h0;
        failures = 0;
        check_count = 0;
        cycles = 0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        wait_n(1);
        // reset state and register map
        `CHK("nmi type", 8'h02, nmi_type_q)
        `CHK("oe c", 1'b0, c_oe)
        `CHK("ack a idle", 1'b1, c_out_n)
        rdchk(OFS_CTRL, 32'h0000_0000, "ctrl");
        rdchk(OFS_STAT, 32'h0000_0000, "stat");
        rdchk(OFS_MASK, 32'h0000_0010, "mask");
        rdchk(5'h10, 32'h0000_0000, "unmapped");
        end_test("reset");
        // non-maskable request cannot be masked and waits for a boundary
        wb(1'b1, OFS_MASK, 32'h0000_0000);
        rdchk(OFS_MASK, 32'h0000_0010, "mask fixed");
        pins(5'h10, 5'h00);
        pins(5'h00, 5'h10);
        wait_n(4);
        `CHK("no take mid", 1'b0, nmi_take_q)
        `CHK("irq nmi", 1'b1, irq_q)
        rdchk(OFS_STAT, 32'h0000_0010, "stat nmi");
        rdchk(OFS_PEND, 32'h0000_0010, "pend nmi");
        @(posedge clk_sys);
        instr_boundary <= 1'b1;
        wait_n(1);
        `CHK("take", 1'b1, nmi_take_q)
        `CHK("take type", 8'h02, nmi_type_q)
        wait_n(1);
        `CHK("take once", 1'b0, nmi_take_q)
        @(posedge clk_sys);
        instr_boundary <= 1'b0;
        wb(1'b1, OFS_STAT, 32'h0000_0010);
        wait_n(2);
        `CHK("irq clear", 1'b0, irq_q)
        end_test("nmi");
        // edge trigger on pin a, held until acknowledged
        pins(5'h01, 5'h00);
        wait_n(4);
        `CHK("pend a", 4'h1, req_pending_q)
        `CHK("irq masked", 1'b0, irq_q)
        wb(1'b1, OFS_MASK, 32'h0000_0001);
        wait_n(2);
        `CHK("irq a", 1'b1, irq_q)
        wb(1'b1, OFS_STAT, 32'h0000_0001);
        wait_n(2);
        `CHK("irq a clr", 1'b0, irq_q)
        `CHK("pend a held", 4'h1, req_pending_q)
        core_ack(2'h0);
        wait_n(1);
        `CHK("pend a ack", 4'h0, req_pending_q)
        pins(5'h00, 5'h01);
        end_test("edge");
        // level trigger on pins a and b follows the pins, not the ack
        wb(1'b1, OFS_CTRL, 32'h0000_0003);
        pins(5'h03, 5'h00);
        wait_n(4);
        `CHK("pend ab", 4'h3, req_pending_q)
        core_ack(2'h1);
        wait_n(1);
        `CHK("pend ab level", 4'h3, req_pending_q)
        pins(5'h00, 5'h03);
        wait_n(4);
        `CHK("pend ab low", 4'h0, req_pending_q)
        rdchk(OFS_STAT, 32'h0000_0003, "stat ab");
        end_test("level");
        // pins c and d as active-low acknowledge strobes
        wb(1'b1, OFS_CTRL, 32'h0000_0030);
        wait_n(1);
        `CHK("oe c on", 1'b1, c_oe)
        `CHK("oe d on", 1'b1, d_oe)
        pins(5'h04, 5'h00);
        wait_n(4);
        `CHK("pin c ignored", 4'h0, req_pending_q)
        for (int i = 0; i < 2; i++) begin
            core_ack(i[1:0]);
            `CHK("ack a", 1'(i != 0), c_out_n)
            `CHK("ack b", 1'(i != 1), d_out_n)
            wait_n(1);
            `CHK("ack a end", 1'b1, c_out_n)
            `CHK("ack b end", 1'b1, d_out_n)
        end
        pins(5'h00, 5'h04);
        wb(1'b1, OFS_STAT, 32'h0000_001F);
        end_test("ack");
        // slave mode removes pin inputs, non-maskable still works
        wb(1'b1, OFS_CTRL, 32'h0000_0040);
        pins(5'h0F, 5'h00);
        wait_n(5);
        `CHK("slave pend", 4'h0, req_pending_q)
        rdchk(OFS_STAT, 32'h0000_0000, "slave stat");
        pins(5'h10, 5'h0F);
        pins(5'h00, 5'h10);
        wait_n(4);
        rdchk(OFS_STAT, 32'h0000_0010, "slave nmi");
        end_test("slave");
        summarize();
    end
endmodule
`default_nettype wire
